// >>> hw/exec_pkg.sv
// Types and constants of the string, branch and CPU control execution unit
// How it works
// - SFR bit clear: set it, branch PC+4+offset
// - Status-low bit set and branch alters flags
// - Short direct bit base: PC+4, long form PC+5
// - Short direct decrement base: PC+3, long PC+4
// - B/C decrement, branch PC+2 when nonzero
// - Memory byte decremented, written back, branch nonzero
// - Location op sets mapping base upper word
// - Bank select without alt clears alternate flag, loads bank
// - Alternate bank select sets flag, loads bank
// - Interrupt unmask sets global allow flag
// - Interrupt mask clears global allow flag
// - Table move: copy word up, step down
// - Fill stores accumulator, steps pointer, counts C
// - Accumulator swap with destination byte per pass
// - Block copy steps both pointers together
// - Block swap exchanges both bytes, steps both
// - Compare-equal stops at C zero or Z=0
// - Compare-unequal stops at C zero or Z=1
// - Compare-borrow stops at C zero or CY=0
// - Compare-no-borrow stops at C zero or CY=1
// - Block compares subtract source byte, same endings
package exec_pkg;
   typedef enum logic [4:0] {
      TEST_CLEAR_THEN_SET_BRANCH, DEC_BRANCH_B, DEC_BRANCH_C, DEC_BRANCH_MEM,
      LOCATION_OP, BANK_SELECT_OP, REGISTER_SET_TOGGLE_OP, NO_OP,
      INTERRUPT_UNMASK_OP, INTERRUPT_MASK_OP, STANDBY_WRITE_OP, WATCHDOG_WRITE_OP,
      TABLE_WORD_SHIFT_MOVE, STRING_FILL_OP, STRING_SWAP_ACCUMULATOR_OP,
      BLOCK_COPY_OP, BLOCK_SWAP_OP, STRING_COMPARE_OP, BLOCK_COMPARE_OP
   } op_t;
   typedef enum logic [1:0] {TGT_SFR, TGT_SADDR, TGT_STATUS_LOW, TGT_OTHER} tgt_t;
   typedef enum logic [1:0] {WHILE_EQUAL, WHILE_UNEQUAL, WHILE_BORROW, WHILE_NO_BORROW} cmp_t;
   typedef enum logic [2:0] {S_IDLE, S_RD_A, S_RD_B, S_WR_A, S_WR_B, S_STEP} st_t;

   typedef struct packed {
      op_t         op;
      tgt_t        tgt;
      logic        long_form;
      logic [2:0]  bit_sel;
      logic [7:0]  short_branch_offset;
      logic [23:0] addr;
      logic [7:0]  imm;
      logic [2:0]  bank;
      logic        alt;
      logic        down;
      cmp_t        cond;
      logic [19:0] pc;
   } exec_req_t;

   typedef struct packed {
      logic [7:0]  a;
      logic [7:0]  b;
      logic [7:0]  c;
      logic [23:0] destination_pointer;
      logic [23:0] source_pointer;
      logic [7:0]  status_word_low;
   } arch_state_t;

   typedef struct packed {
      logic        global_interrupt_allow_flag;
      logic        alternate_bank_flag;
      logic [2:0]  bank_number_field;
      logic [15:0] location;
      logic [7:0]  standby_control_reg;
      logic [7:0]  watchdog_mode_reg;
   } ctrl_state_t;

   typedef struct packed {
      logic s;
      logic z;
      logic ac;
      logic v;
      logic carry_flag;
   } sub_flags_t;

   localparam logic [2:0]  FLAG_CY = 3'h0;
   localparam logic [2:0]  FLAG_PV = 3'h1;
   localparam logic [2:0]  FLAG_AC = 3'h4;
   localparam logic [2:0]  FLAG_Z  = 3'h6;
   localparam logic [2:0]  FLAG_S  = 3'h7;
   localparam logic [19:0] PC_BASE_2 = 20'h00002;
   localparam logic [19:0] PC_BASE_3 = 20'h00003;
   localparam logic [19:0] PC_BASE_4 = 20'h00004;
   localparam logic [19:0] PC_BASE_5 = 20'h00005;
   localparam logic [23:0] PTR_STEP   = 24'h000001;
   localparam logic [7:0]  TABLE_STEP = 8'h02;
   localparam logic [7:0]  TABLE_HI   = 8'h01;
   localparam logic [7:0]  TABLE_DST  = 8'h02;
   localparam logic [7:0]  TABLE_DSTH = 8'h03;
   localparam logic [7:0]  ONE_BYTE   = 8'h01;
   localparam arch_state_t ARCH_RESET = '0;
   localparam ctrl_state_t CTRL_RESET = '0;
endpackage

// >>> hw/byte_sub_flags.sv
// Byte subtractor that only produces the compare flags
module byte_sub_flags (
   // Operands
   input  wire logic [7:0]            minuend,
   input  wire logic [7:0]            subtrahend,
   // Result flags
   output exec_pkg::sub_flags_t       flags
);
   logic [8:0] diff;
   logic [4:0] low_diff;

   always_comb begin
      diff             = {1'b0, minuend} - {1'b0, subtrahend};
      low_diff         = {1'b0, minuend[3:0]} - {1'b0, subtrahend[3:0]};
      flags.s          = diff[7];
      flags.z          = (diff[7:0] == 8'h00);
      flags.ac         = low_diff[4];
      flags.v          = (minuend[7] ^ subtrahend[7]) & (minuend[7] ^ diff[7]);
      flags.carry_flag = diff[8];
   end
endmodule // byte_sub_flags

// >>> hw/string_branch_control_exec.sv
// Execution unit for bit-set branch, decrement loop, CPU control and string ops
module string_branch_control_exec (
   // Clock and reset
   input  wire logic                   clk,
   input  wire logic                   srst,
   // Operation request
   input  wire logic                   req_valid,
   output logic                        req_ready,
   input  wire exec_pkg::exec_req_t    req,
   // Completion
   output logic                        done,
   output logic                        branch_taken,
   output logic [19:0]                 branch_target,
   // Architectural state load and view
   input  wire logic                   load_valid,
   input  wire exec_pkg::arch_state_t  load_state,
   output exec_pkg::arch_state_t       arch,
   output exec_pkg::ctrl_state_t       ctrl,
   // Byte memory port, same clock
   output logic                        mem_req,
   output logic                        mem_we,
   output logic [23:0]                 mem_addr,
   output logic [7:0]                  mem_wdata,
   input  wire logic [7:0]             mem_rdata,
   input  wire logic                   mem_ack
);
   exec_pkg::st_t        st;
   exec_pkg::st_t        next_st;
   exec_pkg::exec_req_t  cur;
   exec_pkg::exec_req_t  next_cur;
   exec_pkg::arch_state_t next_arch;
   exec_pkg::ctrl_state_t next_ctrl;
   exec_pkg::sub_flags_t fl;
   logic [7:0]           byte0;
   logic [7:0]           next_byte0;
   logic [7:0]           byte1;
   logic [7:0]           next_byte1;
   logic [7:0]           cnt;
   logic [7:0]           next_cnt;
   logic [7:0]           waddr;
   logic [7:0]           next_waddr;
   logic                 next_done;
   logic                 next_taken;
   logic [19:0]          next_target;
   logic                 accepted;
   logic                 bit_clear;
   logic [7:0]           new_c;
   logic [7:0]           table_hi;

   // Stage order is rd_a, rd_b, wr_a, wr_b; bit 0 is rd_a
   function automatic logic [3:0] needs(input exec_pkg::op_t op, input logic clr);
      case (op)
         exec_pkg::TEST_CLEAR_THEN_SET_BRANCH: needs = {1'b0, clr, 2'b01};
         exec_pkg::DEC_BRANCH_MEM:             needs = 4'h5;
         exec_pkg::TABLE_WORD_SHIFT_MOVE:      needs = 4'hF;
         exec_pkg::STRING_FILL_OP:             needs = 4'h4;
         exec_pkg::STRING_SWAP_ACCUMULATOR_OP: needs = 4'h5;
         exec_pkg::BLOCK_COPY_OP:              needs = 4'h6;
         exec_pkg::BLOCK_SWAP_OP:              needs = 4'hF;
         exec_pkg::STRING_COMPARE_OP:          needs = 4'h1;
         exec_pkg::BLOCK_COMPARE_OP:           needs = 4'h3;
         default:                              needs = 4'h0;
      endcase
   endfunction

   function automatic exec_pkg::st_t pick(input logic [3:0] need, input logic [2:0] from);
      pick = exec_pkg::S_STEP;
      for (int i = 3; i >= 0; i--) begin
         if (need[i] && 3'(i) >= from) begin
            pick = exec_pkg::st_t'(3'(i + 1));
         end
      end
   endfunction

   function automatic logic [19:0] target_of(input exec_pkg::exec_req_t r);
      logic [19:0] base;
      base = exec_pkg::PC_BASE_3;
      case (r.op)
         exec_pkg::TEST_CLEAR_THEN_SET_BRANCH: begin
            if (r.tgt == exec_pkg::TGT_SFR) begin
               base = exec_pkg::PC_BASE_4;
            end else if (r.tgt == exec_pkg::TGT_SADDR) begin
               base = r.long_form ? exec_pkg::PC_BASE_5 : exec_pkg::PC_BASE_4;
            end
         end
         exec_pkg::DEC_BRANCH_B, exec_pkg::DEC_BRANCH_C: base = exec_pkg::PC_BASE_2;
         exec_pkg::DEC_BRANCH_MEM: base = r.long_form ? exec_pkg::PC_BASE_4 : exec_pkg::PC_BASE_3;
         default: base = exec_pkg::PC_BASE_3;
      endcase
      target_of = r.pc + base + {{12{r.short_branch_offset[7]}}, r.short_branch_offset};
   endfunction

   function automatic logic stop_on(input exec_pkg::cmp_t c, input logic z, input logic cy);
      case (c)
         exec_pkg::WHILE_EQUAL:   stop_on = !z;
         exec_pkg::WHILE_UNEQUAL: stop_on = z;
         exec_pkg::WHILE_BORROW:  stop_on = !cy;
         default:                 stop_on = cy;
      endcase
   endfunction

   // Block compares take the source byte, string compares the accumulator
   byte_sub_flags u_sub (
      .minuend    (byte0),
      .subtrahend ((cur.op == exec_pkg::BLOCK_COMPARE_OP) ? byte1 : arch.a),
      .flags      (fl)
   );

   assign accepted  = req_valid && (st == exec_pkg::S_IDLE);
   assign req_ready = (st == exec_pkg::S_IDLE);
   assign bit_clear = !((st == exec_pkg::S_RD_A) ? mem_rdata[cur.bit_sel] : byte0[cur.bit_sel]);
   assign new_c     = arch.c - exec_pkg::ONE_BYTE;
   assign table_hi  = cnt - exec_pkg::ONE_BYTE;

   // Memory port is decoded from registered state only
   always_comb begin
      mem_req   = (st == exec_pkg::S_RD_A) || (st == exec_pkg::S_RD_B) ||
                  (st == exec_pkg::S_WR_A) || (st == exec_pkg::S_WR_B);
      mem_we    = (st == exec_pkg::S_WR_A) || (st == exec_pkg::S_WR_B);
      mem_addr  = arch.destination_pointer;
      mem_wdata = byte0;
      if (cur.op == exec_pkg::TABLE_WORD_SHIFT_MOVE) begin
         if (st == exec_pkg::S_RD_A) begin
            mem_addr = {cur.addr[23:8], waddr};
         end else if (st == exec_pkg::S_RD_B) begin
            mem_addr = {cur.addr[23:8], waddr + exec_pkg::TABLE_HI};
         end else if (st == exec_pkg::S_WR_A) begin
            mem_addr = {cur.addr[23:8], waddr + exec_pkg::TABLE_DST};
         end else begin
            mem_addr  = {cur.addr[23:8], waddr + exec_pkg::TABLE_DSTH};
            mem_wdata = byte1;
         end
      end else if (cur.op == exec_pkg::TEST_CLEAR_THEN_SET_BRANCH) begin
         mem_addr  = cur.addr;
         mem_wdata = byte0 | (8'h01 << cur.bit_sel);
      end else if (cur.op == exec_pkg::DEC_BRANCH_MEM) begin
         mem_addr  = cur.addr;
         mem_wdata = byte0 - exec_pkg::ONE_BYTE;
      end else if (st == exec_pkg::S_RD_B || st == exec_pkg::S_WR_B) begin
         mem_addr = arch.source_pointer;
         mem_wdata = byte0;
      end else if (cur.op == exec_pkg::STRING_FILL_OP || cur.op == exec_pkg::STRING_SWAP_ACCUMULATOR_OP) begin
         mem_wdata = arch.a;
      end else begin
         mem_wdata = byte1;
      end
   end

   always_comb begin
      next_st     = st;
      next_cur    = cur;
      next_arch   = arch;
      next_ctrl   = ctrl;
      next_byte0  = byte0;
      next_byte1  = byte1;
      next_cnt    = cnt;
      next_waddr  = waddr;
      next_done   = 1'b0;
      next_taken  = branch_taken;
      next_target = branch_target;
      case (st)
         exec_pkg::S_IDLE: begin
            if (load_valid) begin
               next_arch = load_state;
            end
            if (req_valid) begin
               next_cur    = req;
               next_cnt    = req.imm;
               next_waddr  = req.addr[7:0];
               next_target = target_of(req);
               next_taken  = 1'b0;
               next_done   = 1'b1;
               case (req.op)
                  exec_pkg::TEST_CLEAR_THEN_SET_BRANCH: begin
                     if (req.tgt == exec_pkg::TGT_STATUS_LOW) begin
                        // Target is the flag byte itself, so flags move too
                        next_taken = !arch.status_word_low[req.bit_sel];
                        next_arch.status_word_low[req.bit_sel] = 1'b1;
                     end else begin
                        next_done = 1'b0;
                        next_st   = exec_pkg::S_RD_A;
                     end
                  end
                  exec_pkg::DEC_BRANCH_B: begin
                     next_arch.b = arch.b - exec_pkg::ONE_BYTE;
                     next_taken  = (arch.b != exec_pkg::ONE_BYTE);
                  end
                  exec_pkg::DEC_BRANCH_C: begin
                     next_arch.c = new_c;
                     next_taken  = (new_c != 8'h00);
                  end
                  exec_pkg::LOCATION_OP: next_ctrl.location = req.addr[15:0];
                  exec_pkg::BANK_SELECT_OP: begin
                     next_ctrl.alternate_bank_flag = req.alt;
                     next_ctrl.bank_number_field   = req.bank;
                  end
                  exec_pkg::REGISTER_SET_TOGGLE_OP: begin
                     next_ctrl.alternate_bank_flag = !ctrl.alternate_bank_flag;
                  end
                  exec_pkg::INTERRUPT_UNMASK_OP: next_ctrl.global_interrupt_allow_flag = 1'b1;
                  exec_pkg::INTERRUPT_MASK_OP:   next_ctrl.global_interrupt_allow_flag = 1'b0;
                  exec_pkg::STANDBY_WRITE_OP:    next_ctrl.standby_control_reg = req.imm;
                  exec_pkg::WATCHDOG_WRITE_OP:   next_ctrl.watchdog_mode_reg = req.imm;
                  exec_pkg::NO_OP:               next_done = 1'b1;
                  default: begin
                     next_done = 1'b0;
                     next_st   = pick(needs(req.op, 1'b1), 3'h0);
                  end
               endcase
            end
         end
         exec_pkg::S_RD_A, exec_pkg::S_RD_B, exec_pkg::S_WR_A, exec_pkg::S_WR_B: begin
            if (mem_ack) begin
               if (st == exec_pkg::S_RD_A) begin
                  next_byte0 = mem_rdata;
               end else if (st == exec_pkg::S_RD_B) begin
                  next_byte1 = mem_rdata;
               end
               next_st = pick(needs(cur.op, bit_clear), st);
            end
         end
         default: begin
            // Step stage: move pointers, count down, decide whether to go round
            next_st = exec_pkg::S_IDLE;
            case (cur.op)
               exec_pkg::TEST_CLEAR_THEN_SET_BRANCH: begin
                  next_taken = !byte0[cur.bit_sel];
                  next_done  = 1'b1;
               end
               exec_pkg::DEC_BRANCH_MEM: begin
                  next_taken = (byte0 != exec_pkg::ONE_BYTE);
                  next_done  = 1'b1;
               end
               exec_pkg::TABLE_WORD_SHIFT_MOVE: begin
                  next_waddr = waddr - exec_pkg::TABLE_STEP;
                  next_cnt   = table_hi;
                  if (table_hi == 8'h00) begin
                     next_done = 1'b1;
                  end else begin
                     next_st = pick(needs(cur.op, 1'b1), 3'h0);
                  end
               end
               default: begin
                  next_arch.c = new_c;
                  next_arch.destination_pointer = cur.down ? arch.destination_pointer - exec_pkg::PTR_STEP
                                                           : arch.destination_pointer + exec_pkg::PTR_STEP;
                  if (cur.op == exec_pkg::BLOCK_COPY_OP || cur.op == exec_pkg::BLOCK_SWAP_OP ||
                      cur.op == exec_pkg::BLOCK_COMPARE_OP) begin
                     // Both pointers step in the same direction
                     next_arch.source_pointer = cur.down ? arch.source_pointer - exec_pkg::PTR_STEP
                                                         : arch.source_pointer + exec_pkg::PTR_STEP;
                  end
                  if (cur.op == exec_pkg::STRING_SWAP_ACCUMULATOR_OP) begin
                     next_arch.a = byte0;
                  end
                  if (cur.op == exec_pkg::STRING_COMPARE_OP || cur.op == exec_pkg::BLOCK_COMPARE_OP) begin
                     // Flags only; the difference is never stored
                     next_arch.status_word_low[exec_pkg::FLAG_S]  = fl.s;
                     next_arch.status_word_low[exec_pkg::FLAG_Z]  = fl.z;
                     next_arch.status_word_low[exec_pkg::FLAG_AC] = fl.ac;
                     next_arch.status_word_low[exec_pkg::FLAG_PV] = fl.v;
                     next_arch.status_word_low[exec_pkg::FLAG_CY] = fl.carry_flag;
                  end
                  if (new_c == 8'h00 || ((cur.op == exec_pkg::STRING_COMPARE_OP ||
                      cur.op == exec_pkg::BLOCK_COMPARE_OP) && stop_on(cur.cond, fl.z, fl.carry_flag))) begin
                     next_done = 1'b1;
                  end else begin
                     next_st = pick(needs(cur.op, 1'b1), 3'h0);
                  end
               end
            endcase
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         st            <= exec_pkg::S_IDLE;
         cur           <= '0;
         arch          <= exec_pkg::ARCH_RESET;
         ctrl          <= exec_pkg::CTRL_RESET;
         byte0         <= 8'h00;
         byte1         <= 8'h00;
         cnt           <= 8'h00;
         waddr         <= 8'h00;
         done          <= 1'b0;
         branch_taken  <= 1'b0;
         branch_target <= 20'h00000;
      end else begin
         st            <= next_st;
         cur           <= next_cur;
         arch          <= next_arch;
         ctrl          <= next_ctrl;
         byte0         <= next_byte0;
         byte1         <= next_byte1;
         cnt           <= next_cnt;
         waddr         <= next_waddr;
         done          <= next_done;
         branch_taken  <= next_taken;
         branch_target <= next_target;
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);

   property p_unmask;
      accepted && req.op == exec_pkg::INTERRUPT_UNMASK_OP |=> ctrl.global_interrupt_allow_flag && done;
   endproperty
   a_unmask: assert property (p_unmask) else $error("unmask did not set allow flag");

   property p_mask;
      accepted && req.op == exec_pkg::INTERRUPT_MASK_OP |=> !ctrl.global_interrupt_allow_flag && done;
   endproperty
   a_mask: assert property (p_mask) else $error("mask did not clear allow flag");

   property p_bank_select;
      accepted && req.op == exec_pkg::BANK_SELECT_OP |=>
         ctrl.bank_number_field == $past(req.bank) && ctrl.alternate_bank_flag == $past(req.alt);
   endproperty
   a_bank_select: assert property (p_bank_select) else $error("bank select wrong");

   property p_toggle;
      accepted && req.op == exec_pkg::REGISTER_SET_TOGGLE_OP |=>
         ctrl.alternate_bank_flag != $past(ctrl.alternate_bank_flag) && $stable(ctrl.bank_number_field);
   endproperty
   a_toggle: assert property (p_toggle) else $error("register set toggle wrong");

   property p_dec_b;
      accepted && req.op == exec_pkg::DEC_BRANCH_B |=>
         arch.b == $past(arch.b) - 8'h01 && branch_taken == (arch.b != 8'h00) && done;
   endproperty
   a_dec_b: assert property (p_dec_b) else $error("B decrement branch wrong");

   property p_status_bit;
      accepted && req.op == exec_pkg::TEST_CLEAR_THEN_SET_BRANCH && req.tgt == exec_pkg::TGT_STATUS_LOW |=>
         branch_taken == !$past(arch.status_word_low[req.bit_sel]) && arch.status_word_low[cur.bit_sel];
   endproperty
   a_status_bit: assert property (p_status_bit) else $error("status bit set branch wrong");

   property p_fill_data;
      st == exec_pkg::S_WR_A && cur.op == exec_pkg::STRING_FILL_OP |->
         mem_we && mem_wdata == arch.a && mem_addr == arch.destination_pointer;
   endproperty
   a_fill_data: assert property (p_fill_data) else $error("fill write wrong");

   property p_cmp_end;
      done && cur.op == exec_pkg::STRING_COMPARE_OP |->
         arch.c == 8'h00 || stop_on(cur.cond, arch.status_word_low[exec_pkg::FLAG_Z],
                                    arch.status_word_low[exec_pkg::FLAG_CY]);
   endproperty
   a_cmp_end: assert property (p_cmp_end) else $error("compare ended early");

   property p_standby_only;
      $changed(ctrl.standby_control_reg) |-> $past(accepted && req.op == exec_pkg::STANDBY_WRITE_OP);
   endproperty
   a_standby_only: assert property (p_standby_only) else $error("standby written by other op");

   property p_sfr_base;
      done && branch_taken && cur.op == exec_pkg::TEST_CLEAR_THEN_SET_BRANCH && cur.tgt == exec_pkg::TGT_SFR |->
         branch_target == cur.pc + 20'h00004 + {{12{cur.short_branch_offset[7]}}, cur.short_branch_offset};
   endproperty
   a_sfr_base: assert property (p_sfr_base) else $error("sfr branch target wrong");

   property p_copy_step;
      st == exec_pkg::S_STEP && cur.op == exec_pkg::BLOCK_COPY_OP |=>
         arch.destination_pointer - $past(arch.destination_pointer) ==
         arch.source_pointer - $past(arch.source_pointer) && arch.c == $past(arch.c) - 8'h01;
   endproperty
   a_copy_step: assert property (p_copy_step) else $error("block copy step wrong");

   c_cmp_done: cover property (done && cur.op == exec_pkg::BLOCK_COMPARE_OP);
   c_swap_done: cover property (done && cur.op == exec_pkg::BLOCK_SWAP_OP);
   c_mem_bit_taken: cover property (done && branch_taken && cur.op == exec_pkg::TEST_CLEAR_THEN_SET_BRANCH);
   c_table_loop: cover property (st == exec_pkg::S_STEP && cur.op == exec_pkg::TABLE_WORD_SHIFT_MOVE
                                 ##1 st != exec_pkg::S_IDLE);
endmodule // string_branch_control_exec

// >>> tb/mem_model.sv
// Byte memory model facing the execution unit
module mem_model (
   // Memory port
   input  wire logic        clk,
   input  wire logic        slow,
   input  wire logic        mem_req,
   input  wire logic        mem_we,
   input  wire logic [23:0] mem_addr,
   input  wire logic [7:0]  mem_wdata,
   output logic [7:0]       mem_rdata,
   output logic             mem_ack
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] m [256] = '{default: 8'h00};
   logic [1:0] w = 2'h0;
   // Slow mode stalls each access two cycles
   assign mem_ack = mem_req && (!slow || w == 2'h2);
   // Inverted byte when not acked, never stale data
   assign mem_rdata = mem_ack ? m[mem_addr[7:0]] : ~m[mem_addr[7:0]];
   always @(posedge clk) begin
      w <= (mem_req && !mem_ack) ? w + 2'h1 : 2'h0;
      if (mem_ack && mem_we) m[mem_addr[7:0]] <= mem_wdata;
   end
endmodule // mem_model

// >>> tb/string_branch_control_exec_tb.sv
// Self-checking bench of the string, branch and control unit
module string_branch_control_exec_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, srst, req_valid, req_ready, done, branch_taken, load_valid, mem_req, mem_we, mem_ack, slow;
   logic [19:0] branch_target;
   logic [23:0] mem_addr;
   logic [7:0] mem_wdata, mem_rdata;
   exec_pkg::exec_req_t req;
   exec_pkg::arch_state_t load_state, arch;
   exec_pkg::ctrl_state_t ctrl;
   int fails, num_checks, k, j, n;
   // Op codes follow the enum order of the package
   // Last entry is a no-op that carries a live immediate and bank field
   logic [4:0] ops[9] = '{5'h08, 5'h05, 5'h06, 5'h05, 5'h04, 5'h0A, 5'h0B, 5'h09, 5'h07};
   logic [7:0] xs[9] = '{8'h00, 8'h0D, 8'h00, 8'h03, 8'h00, 8'h5A, 8'hA5, 8'h00, 8'h3C};
   logic [39:0] ex[9] = '{40'h1000000000, 40'h1D00000000, 40'h1500000000, 40'h1300000000, 40'h1312340000,
      40'h1312345A00, 40'h1312345AA5, 40'h0312345AA5, 40'h0312345AA5};
   string_branch_control_exec i_dut (.clk, .srst, .req_valid, .req_ready, .req, .done, .branch_taken, .branch_target,
      .load_valid, .load_state, .arch, .ctrl, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_rdata, .mem_ack);
   mem_model i_mem (.clk, .slow, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_rdata, .mem_ack);
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task automatic chk(input logic [47:0] got, input logic [47:0] exp);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
      end
   endtask
   task automatic wrap_up;
      $display("checks %0d fails %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic go(input logic [4:0] o, input logic [23:0] ad, input logic [7:0] x);
      @(negedge clk);
      req = '{exec_pkg::op_t'(o), exec_pkg::tgt_t'(x[7:6]), x[4], x[2:0], 8'h10, ad, x, x[2:0], x[3], x[5],
         exec_pkg::cmp_t'(x[7:6]), 20'h00100};
      req_valid = 1'b1;
      @(negedge clk);
      req_valid = 1'b0;
      for (n = 0; n < 40 && done !== 1'b1; n++)
         @(negedge clk);
      if (n == 40) begin
         fails++;
         wrap_up();
      end
   endtask
   task automatic ld(input logic [7:0] c);
      @(negedge clk);
      load_state = '{8'h77, 8'h02, c, 24'h000010, 24'h000020, 8'h00};
      load_valid = 1'b1;
      @(negedge clk);
      load_valid = 1'b0;
   endtask
   initial begin
      {req_valid, load_valid, slow, req, load_state} = '0;
      srst = 1'b1;
      repeat (20) @(negedge clk);
      srst = 1'b0;
      ld(8'h04);
      go(5'h01, 24'h000000, 8'h00);
      chk({branch_taken, branch_target, arch.b}, {1'b1, 20'h00112, 8'h01});
      go(5'h01, 24'h000000, 8'h00);
      chk({branch_taken, arch.b}, {1'b0, 8'h00});
      for (k = 0; k < 9; k++) begin
         go(ops[k], 24'h001234, xs[k]);
         chk(ctrl, ex[k]);
      end
      $display("control tests done");
      go(5'h00, 24'h000040, 8'h03);
      chk({branch_taken, branch_target, i_mem.m[8'h40]}, {1'b1, 20'h00114, 8'h08});
      go(5'h00, 24'h000040, 8'h03);
      chk({branch_taken, i_mem.m[8'h40]}, {1'b0, 8'h08});
      slow = 1'b1;
      go(5'h00, 24'h000041, 8'h51);
      chk({branch_taken, branch_target, i_mem.m[8'h41]}, {1'b1, 20'h00115, 8'h02});
      go(5'h00, 24'h000000, 8'h86);
      chk({branch_taken, branch_target, arch.status_word_low}, {1'b1, 20'h00113, 8'h40});
      for (k = 0; k < 2; k++) begin
         go(5'h03, 24'h000041, 8'(16 - k * 16));
         chk({branch_taken, branch_target, i_mem.m[8'h41]}, k ? 32'h00011300 : 32'h10011401);
      end
      slow = 1'b0;
      go(5'h0D, 24'h000000, 8'h00);
      chk({i_mem.m[8'h10], i_mem.m[8'h11], i_mem.m[8'h12], i_mem.m[8'h13], arch.c, arch.destination_pointer[7:0]},
         48'h777777770014);
      i_mem.m[8'h12] = 8'h70;
      for (k = 0; k < 4; k++)
         i_mem.m[8'h20 + k] = 8'h77;
      for (j = 0; j < 2; j++) begin
         for (k = 0; k < 4; k++) begin
            ld(8'h04);
            go(j ? 5'h12 : 5'h11, 24'h000000, 8'(k << 6));
            chk(arch.c, (k % 3) ? 8'h03 : 8'h01);
         end
      end
      i_mem.m[8'h20] = 8'hAA;
      i_mem.m[8'h1F] = 8'hBB;
      ld(8'h02);
      go(5'h10, 24'h000000, 8'h20);
      chk({i_mem.m[8'h10], i_mem.m[8'h20], i_mem.m[8'h0F], i_mem.m[8'h1F]}, 32'hAA77BB00);
      chk({arch.destination_pointer[7:0], arch.source_pointer[7:0], arch.c}, 24'h0E1E00);
      ld(8'h01);
      go(5'h0E, 24'h000000, 8'h00);
      chk({arch.a, i_mem.m[8'h10], arch.destination_pointer[7:0], arch.c}, 32'hAA771100);
      // Downward copy of two bytes, second one lands below the start
      i_mem.m[8'h20] = 8'h5C;
      ld(8'h02);
      go(5'h0F, 24'h000000, 8'h20);
      chk({i_mem.m[8'h10], i_mem.m[8'h0F], arch.source_pointer[7:0], arch.c}, 32'h5C001E00);
      for (k = 0; k < 4; k++)
         i_mem.m[8'h30 + k] = 8'(k + 1);
      go(5'h0C, 24'h000032, 8'h02);
      chk({req_ready, i_mem.m[8'h32], i_mem.m[8'h33], i_mem.m[8'h34], i_mem.m[8'h35]}, 33'h101020304);
      $display("memory tests done");
      wrap_up();
   end
endmodule // string_branch_control_exec_tb
